// ===== bench/modbus_slave_id_report_bench.sv
// modbus_slave_id_report_bench: random and corner requests, map lookups.
// assumes: responder built with a short deadline of 64 cycles.
`timescale 1ns/1ns
module modbus_slave_id_report_bench;
  import msid_pkg::*;
  localparam logic [7:0]  DEVID = 8'h3C;  // arbitrary value
  localparam logic [31:0] FW    = 32'h4048_F5C3;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [7:0]        station_addr = 8'h01;
  logic [7:0]        mode_code = 8'h00;
  logic              ascii_mode = 1'b0;
  logic [1:0]        variant_pin = 2'h0;
  logic [15:0]       map_addr = 16'h0000;
  logic              map_wr = 1'b0;
  logic              stall = 1'b0;
  logic              hold = 1'b0;
  logic [7:0]        rx_data, tx_data;
  logic              rx_valid, rx_last, tx_valid, tx_ready;
  logic              map_hit, map_wr_ok, map_wide, map_rw_bank, map_word;
  logic [IDX_W-1:0]  map_index;
  logic              stop_two, bcast_seen, resp_late;
  int                n_errors = 0;
  int                check_count = 0;
  int                n_bc = 0;
  int                n_late = 0;
  integer            seed = 32'h6d22;
  logic [7:0]        st;

  always #4 clk = ~clk;

  msid_id_report #(.DEV_ID(DEVID), .OC_FIT(8'h01), .FW_VERSION(FW),
    .RESP_CYCLES(64)) DUT (
    .clk(clk), .nrst(nrst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .station_addr(station_addr),
    .mode_code(mode_code), .ascii_mode(ascii_mode),
    .variant_pin(variant_pin), .map_addr(map_addr), .map_wr(map_wr),
    .map_hit(map_hit), .map_wr_ok(map_wr_ok), .map_wide(map_wide),
    .map_rw_bank(map_rw_bank), .map_word(map_word),
    .map_index(map_index), .stop_two(stop_two),
    .bcast_seen(bcast_seen), .resp_late(resp_late));

  msid_master PM (
    .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .stall(stall), .hold(hold));

  always @(posedge clk) begin
    if (bcast_seen === 1'b1) n_bc++;
    if (resp_late === 1'b1) n_late++;
  end

  function automatic logic [15:0] crc(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc

  function automatic logic [7:0] lrc(input logic [7:0] f[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (f[i]) s = s + f[i];
    return 8'h00 - s;
  endfunction : lrc

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  // bad flips one checksum bit; want says whether a reply is due
  task automatic req(input logic [7:0] a, input logic asc,
                     input logic bad, input logic want);
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [15:0] c;
    int          n;
    ascii_mode <= asc;
    f = '{a, FN_REPORT_ID};
    c = crc(f);
    if (asc) f.push_back(lrc(f) ^ {7'h00, bad});
    else f = '{a, FN_REPORT_ID, c[7:0] ^ {7'h00, bad}, c[15:8]};
    e = '{station_addr, 8'h11, 8'h08, DEVID, 8'hFF, 8'h01,
          {6'h00, variant_pin}, FW[31:24], FW[23:16], FW[15:8], FW[7:0]};
    c = crc(e);
    if (asc) e.push_back(lrc(e));
    else e = '{e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7], e[8],
               e[9], e[10], c[7:0], c[15:8]};
    PM.got.delete();
    PM.send(f);
    n = want ? e.size() : 0;
    for (int i = 0; i < 200 && PM.got.size() < n; i++) @(posedge clk);
    if (PM.got.size() < n) begin
      n_errors++;
      $display("Error at %0t: reply timed out", $time);
      final_report();
    end
    repeat (30) @(posedge clk);
    chk(8'(PM.got.size()), 8'(n), "reply length");
    if (want && PM.got.size() == n) begin
      foreach (e[i]) chk(PM.got[i], e[i], "reply byte");
    end
  endtask : req

  task automatic map_chk(input logic [15:0] a, input logic w);
    int   o;
    logic h, rw, wd;
    @(posedge clk);
    map_addr <= a;
    map_wr   <= w;
    repeat (2) @(posedge clk);
    h = 1'b1;
    rw = 1'b0;
    wd = 1'b0;
    o = 0;
    if (a >= 7000 && a < 7200) o = a - 7000;
    else if (a >= 7200 && a < 7400) {rw, o} = {1'b1, 32'(a - 7200)};
    else if (a >= 7500 && a < 7600) {wd, o} = {1'b1, 32'((a - 7500) * 2)};
    else if (a >= 7600 && a < 7700) {rw, wd, o} = {2'b11, 32'((a - 7600) * 2)};
    else h = 1'b0;
    chk({7'h00, map_hit}, {7'h00, h}, "map hit");
    chk({7'h00, map_wr_ok}, {7'h00, w & rw}, "write ok");
    if (h) begin
      chk({7'h00, map_wide}, {7'h00, wd}, "wide");
      chk({7'h00, map_rw_bank}, {7'h00, rw}, "rw bank");
      chk({1'b0, map_index}, 8'(o >> 1), "index");
      chk({7'h00, map_word}, {7'h00, o[0]}, "word");
    end
  endtask : map_chk

  initial begin
    int al[14];
    logic [15:0] c21;
    al = '{6999, 7000, 7001, 7199, 7200, 7201, 7399, 7400, 7499, 7500,
           7599, 7600, 7699, 7700};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    stall <= 1'b1;
    for (int v = 0; v < 8; v++) begin
      st = 8'(($random(seed) & 32'h7f) + 1);
      station_addr <= st;
      variant_pin <= 2'(v);
      ascii_mode <= v[2];
      repeat (4) @(posedge clk);
      req(st, v[2], 1'b0, 1'b1);
    end
    station_addr <= ADDR_MAX;
    ascii_mode <= 1'b0;
    repeat (2) @(posedge clk);
    req(ADDR_MAX, 1'b0, 1'b0, 1'b1);
    req(8'h05, 1'b0, 1'b0, 1'b0);
    req(ADDR_MAX, 1'b0, 1'b1, 1'b0);
    req(ADDR_MAX, 1'b1, 1'b1, 1'b0);
    n_bc = 0;
    req(ADDR_BCAST, 1'b0, 1'b0, 1'b0);
    req(ADDR_BCAST, 1'b1, 1'b0, 1'b0);
    chk(8'(n_bc), 8'h02, "broadcast pulses");
    station_addr <= 8'hF8;
    repeat (2) @(posedge clk);
    req(8'hF8, 1'b0, 1'b0, 1'b0);
    station_addr <= 8'h21;
    // deadline: the master takes no byte until after the deadline, reply must be cut short
    hold <= 1'b1;
    n_late = 0;
    PM.got.delete();
    c21 = crc('{8'h21, 8'h11});
    PM.send('{8'h21, 8'h11, c21[7:0], c21[15:8]});
    repeat (100) @(posedge clk);
    chk(8'(n_late), 8'h01, "late pulse");
    hold <= 1'b0;
    repeat (30) @(posedge clk);
    check_count++;
    if (PM.got.size() >= 13 || PM.got.size() == 0) begin
      n_errors++;
      $display("Error at %0t: late reply not cut short", $time);
    end
    req(8'h21, 1'b0, 1'b0, 1'b1);
    for (int m = 0; m < 4; m++) begin
      mode_code <= 8'(m);
      repeat (3) @(posedge clk);
      chk({7'h00, stop_two}, {7'h00, m == 2}, "stop bits");
    end
    foreach (al[i]) begin
      map_chk(16'(al[i]), 1'b0);
      map_chk(16'(al[i]), 1'b1);
    end
    for (int i = 0; i < 40; i++) begin
      map_chk(16'(6900 + ($random(seed) & 32'h3ff)), 1'($random(seed)));
    end
    final_report();
  end
endmodule : modbus_slave_id_report_bench

// ===== bench/msid_master.sv
// msid_master: stands for the bus master; sends request frames and
// collects reply bytes, with random or held stalls on the reply side.
// assumes: same clock as the responder; the bench calls send, reads got.
`timescale 1ns/1ns
module msid_master (
  // clock
  input  wire logic       clk,
  // request side
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  // reply side
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // stall control
  input  wire logic       stall,
  input  wire logic       hold
);
  logic [7:0] got[$];
  integer     seed = 32'h6d22;

  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
  end

  // a slow master is legal, so the reply side stalls now and then
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_data);
    end
    tx_ready <= !hold && !(stall && (($random(seed) & 3) == 0));
  end

  // bytes go back to back; the data line shows junk between frames
  task automatic send(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge clk);
      rx_data  <= f[i];
      rx_valid <= 1'b1;
      rx_last  <= (i == f.size() - 1);
    end
    @(posedge clk);
    rx_data  <= ~f[f.size() - 1];
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
  endtask : send
endmodule : msid_master

// ===== rtl/msid_buf.sv
// msid_buf: shift-register buffer, head entry is the output flop.
// assumes: fill and drain on the same clock; DEPTH of at least two.
`timescale 1ns/1ns
module msid_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0]     mem [DEPTH];
  logic [DEPTH-1:0] occ;
  logic [DEPTH+1:0] occ_x;
  logic             push;
  logic             pop;

  // occ_x[i+1] is entry i; ends padded so every entry sees a neighbour
  assign occ_x     = {1'b0, occ, 1'b1};
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign in_ready  = ~occ[DEPTH-1];
  assign out_valid = occ[0];
  assign out_data  = mem[0];

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      logic [W-1:0] up;
      logic [W-1:0] data_r;
      logic         occ_r;
      logic         next_occ;
      logic [W-1:0] next_data;
      if (i == DEPTH - 1) begin : g_top
        assign up = in_data;
      end else begin : g_mid
        assign up = mem[i+1];
      end
      assign next_occ  = pop ? (occ_x[i+2] | (push & occ_x[i+1]))
                             : (occ_x[i+1] | (push & occ_x[i]));
      assign next_data = pop ? (occ_x[i+2] ? up : in_data)
                             : (occ_x[i+1] ? data_r : in_data);
      always_ff @(posedge clk) begin
        if (!nrst) begin
          occ_r  <= 1'b0;
          data_r <= '0;
        end else begin
          occ_r  <= next_occ;
          data_r <= next_data;
        end
      end
      assign occ[i] = occ_r;
      assign mem[i] = data_r;
    end
  endgenerate

endmodule : msid_buf

// ===== rtl/msid_id_report.sv
// msid_id_report: identification-report responder and holding-register
// range decoder of a serial slave.
// assumes: a line layer delivers request bytes with a last-byte marker
// and sends reply bytes (ascii hex coding is done there).
//
// Overview of operation
// - a request of address, function 0x11 and checksum is answered.
// - the reply is address, 0x11, 0x08, id, 0xFF, six field bytes, cks.
// - the reply address byte is the configured station address.
// - field byte one reports the open-collector fitting, 0x01 for two.
// - field byte two codes the input variant 0x00 to 0x03.
// - field bytes three to six are the firmware float, msb first.
// - the checksum is two bytes in rtu framing and one in ascii.
// - framing code 0x02 selects rtu with eight bits and two stops.
// - 7000 to 7199 are read-only pairs mirroring the 7500 words.
// - 7200 to 7399 are writable pairs mirroring the 7600 words.
// - 7500 to 7599 are read-only whole floats that refuse writes.
// - 7600 to 7699 are whole floats open to reads and writes.
// - station addresses 1 to 247 are valid and 0 is a broadcast.
// - reply bytes not queued within 300 ms of the request are dropped.
`timescale 1ns/1ns
module msid_id_report
  import msid_pkg::*;
#(
  parameter logic [7:0]  DEV_ID      = 8'h5A,  // arbitrary value
  parameter logic [7:0]  OC_FIT      = OC_TWO,
  parameter logic [31:0] FW_VERSION  = 32'h3F80_0000,
  parameter int          RESP_CYCLES = RESP_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // request bytes from the line layer
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  // reply bytes to the line layer
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // configuration
  input  wire logic [7:0]  station_addr,
  input  wire logic [7:0]  mode_code,
  input  wire logic        ascii_mode,
  input  wire logic [1:0]  variant_pin,
  // register map lookup
  input  wire logic [15:0] map_addr,
  input  wire logic        map_wr,
  output logic             map_hit,
  output logic             map_wr_ok,
  output logic             map_wide,
  output logic             map_rw_bank,
  output logic             map_word,
  output logic [IDX_W-1:0] map_index,
  // status
  output logic             stop_two,
  output logic             bcast_seen,
  output logic             resp_late
);

  localparam int TW = $clog2(RESP_CYCLES + 1);

  msid_state_t st;
  logic [3:0]  rx_cnt;
  logic [3:0]  idx;
  logic [7:0]  rx_addr;
  logic [7:0]  rx_fn;
  logic [7:0]  rx_sum;
  logic [7:0]  tx_sum;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [TW-1:0] timer;
  logic [1:0]  var_s1;
  logic [1:0]  var_s2;
  logic        use_ascii;
  logic        buf_ready;
  logic [7:0]  pay [PAY_LEN];

  // variant straps come from pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      var_s1 <= 2'h0;
      var_s2 <= 2'h0;
    end else begin
      var_s1 <= variant_pin;
      var_s2 <= var_s1;
    end
  end

  // reply payload
  assign pay[0]  = station_addr;
  assign pay[1]  = FN_REPORT_ID;
  assign pay[2]  = BYTE_COUNT;
  assign pay[3]  = DEV_ID;
  assign pay[4]  = DEV_STATE;
  assign pay[5]  = OC_FIT;
  assign pay[6]  = {6'h00, var_s2};
  assign pay[7]  = FW_VERSION[31:24];
  assign pay[8]  = FW_VERSION[23:16];
  assign pay[9]  = FW_VERSION[15:8];
  assign pay[10] = FW_VERSION[7:0];

  // request side; bytes arriving while a reply is out are dropped
  wire        rx_take   = rx_valid & (st == ST_IDLE);
  wire        frame_end = rx_take & rx_last;
  wire [3:0]  rx_cnt_n  = (rx_cnt == CNT_SAT) ? rx_cnt : rx_cnt + CNT_ONE;
  wire [15:0] rx_crc_n  = msid_crc_step(rx_crc, rx_data);
  wire [7:0]  rx_sum_n  = rx_sum + rx_data;
  wire [7:0]  rx_addr_n = (rx_cnt == CNT_ZERO) ? rx_data : rx_addr;
  wire [7:0]  rx_fn_n   = (rx_cnt == CNT_ONE) ? rx_data : rx_fn;
  wire [3:0]  req_len   = REQ_HDR_LEN
                        + (ascii_mode ? CKS_LEN_ASCII : CKS_LEN_RTU);
  wire        cks_ok    = ascii_mode ? (rx_sum_n == BYTE_ZERO)
                                     : (rx_crc_n == CRC_GOOD);
  wire        stn_ok    = (station_addr >= ADDR_MIN)
                        & (station_addr <= ADDR_MAX);
  wire        frame_ok  = frame_end & cks_ok & (rx_cnt_n == req_len);
  wire        req_ok    = frame_ok & stn_ok & (rx_addr_n == station_addr)
                        & (rx_fn_n == FN_REPORT_ID);
  wire        req_bcast = frame_ok & (rx_addr_n == ADDR_BCAST);

  always_ff @(posedge clk) begin
    if (!nrst || frame_end) begin
      rx_cnt  <= CNT_ZERO;
      rx_addr <= BYTE_ZERO;
      rx_fn   <= BYTE_ZERO;
      rx_crc  <= CRC_INIT;
      rx_sum  <= BYTE_ZERO;
    end else if (rx_take) begin
      rx_cnt  <= rx_cnt_n;
      rx_addr <= rx_addr_n;
      rx_fn   <= rx_fn_n;
      rx_crc  <= rx_crc_n;
      rx_sum  <= rx_sum_n;
    end
  end

  // reply side
  wire        sending   = st != ST_IDLE;
  wire        late      = sending & (timer == TW'(RESP_CYCLES - 1));
  wire        push      = sending & buf_ready & ~late;
  wire        last_pay  = idx == PAY_LAST;
  wire        last_cks  = use_ascii | (idx == CKS_LEN_RTU - CNT_ONE);
  wire [7:0]  lrc_byte  = BYTE_ZERO - tx_sum;
  wire [7:0]  cks_byte  = use_ascii ? lrc_byte
                        : (idx == CNT_ZERO) ? tx_crc[7:0]
                                            : tx_crc[15:8];
  wire [7:0]  push_data = (st == ST_CKS) ? cks_byte : pay[idx];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st        <= ST_IDLE;
      idx       <= CNT_ZERO;
      tx_crc    <= CRC_INIT;
      tx_sum    <= BYTE_ZERO;
      timer     <= '0;
      use_ascii <= 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          idx       <= CNT_ZERO;
          tx_crc    <= CRC_INIT;
          tx_sum    <= BYTE_ZERO;
          timer     <= '0;
          use_ascii <= ascii_mode;
          // broadcast requests never reach here as req_ok
          if (req_ok) st <= ST_SEND;
        end
        ST_SEND: begin
          timer <= timer + 1'b1;
          if (late) begin
            st <= ST_IDLE;
          end else if (push) begin
            tx_crc <= msid_crc_step(tx_crc, push_data);
            tx_sum <= tx_sum + push_data;
            idx    <= last_pay ? CNT_ZERO : idx + CNT_ONE;
            if (last_pay) st <= ST_CKS;
          end
        end
        ST_CKS: begin
          timer <= timer + 1'b1;
          if (late) begin
            st <= ST_IDLE;
          end else if (push) begin
            idx <= idx + CNT_ONE;
            if (last_cks) st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // two entries let the line layer stall without losing a byte
  msid_buf #(.W(8), .DEPTH(2)) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   (push_data),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  // register map decode
  wire        in_ro16 = (map_addr >= MAP_RO16_LO) & (map_addr < MAP_RW16_LO);
  wire        in_rw16 = (map_addr >= MAP_RW16_LO) & (map_addr < MAP_RW16_HI);
  wire        in_ro32 = (map_addr >= MAP_RO32_LO) & (map_addr < MAP_RW32_LO);
  wire        in_rw32 = (map_addr >= MAP_RW32_LO) & (map_addr < MAP_RW32_HI);
  wire        hit     = in_ro16 | in_rw16 | in_ro32 | in_rw32;
  wire        half    = in_ro16 | in_rw16;
  wire        rw      = in_rw16 | in_rw32;
  wire [15:0] off     = in_ro16 ? map_addr - MAP_RO16_LO
                      : in_rw16 ? map_addr - MAP_RW16_LO
                      : in_ro32 ? map_addr - MAP_RO32_LO
                                : map_addr - MAP_RW32_LO;
  // a pair and its whole word share one index, so both views hit one store
  wire [IDX_W-1:0] idx_n = half ? off[IDX_W:1] : off[IDX_W-1:0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      map_hit     <= 1'b0;
      map_wr_ok   <= 1'b0;
      map_wide    <= 1'b0;
      map_rw_bank <= 1'b0;
      map_word    <= 1'b0;
      map_index   <= '0;
      stop_two    <= 1'b0;
      bcast_seen  <= 1'b0;
      resp_late   <= 1'b0;
    end else begin
      map_hit     <= hit;
      map_wr_ok   <= map_wr & hit & rw;
      map_wide    <= hit & ~half;
      map_rw_bank <= hit & rw;
      map_word    <= half & off[0];
      map_index   <= idx_n;
      stop_two    <= mode_code == MODE_RTU_8N2;
      bcast_seen  <= req_bcast;
      resp_late   <= late;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_lo_pushed;
    st == ST_CKS && push && !use_ascii && idx == CNT_ZERO;
  endsequence

  AST_REQ_STARTS: assert property (req_ok |=> st == ST_SEND ##0 idx == 0)
    else $error("accepted request did not start a reply");
  AST_ADDR_BYTE: assert property (
    st == ST_SEND && push && idx == 0 |-> push_data == station_addr)
    else $error("reply address byte wrong");
  AST_COUNT_BYTE: assert property (
    st == ST_SEND && push && idx == 2 |-> push_data == BYTE_COUNT)
    else $error("reply byte count wrong");
  AST_OC_BYTE: assert property (
    st == ST_SEND && push && idx == 5 |-> push_data == OC_FIT)
    else $error("fitting byte wrong");
  AST_VAR_BYTE: assert property (st == ST_SEND && push && idx == 6
    |-> push_data == {6'h00, var_s2})
    else $error("variant byte wrong");
  AST_FW_MSB: assert property (st == ST_SEND && push && idx == 7
    |-> push_data == FW_VERSION[31:24])
    else $error("firmware msb not first");
  AST_RTU_TWO: assert property (s_lo_pushed |=> st == ST_CKS)
    else $error("rtu checksum ended after one byte");
  AST_ASCII_ONE: assert property (
    st == ST_CKS && push && use_ascii |=> st == ST_IDLE)
    else $error("ascii checksum longer than one byte");
  AST_STOP_TWO: assert property (
    $changed(mode_code) |=> stop_two == ($past(mode_code) == MODE_RTU_8N2))
    else $error("framing code not decoded");
  AST_RO_REFUSE: assert property (
    map_wr && (in_ro16 || in_ro32) |=> !map_wr_ok)
    else $error("write accepted in read-only range");
  AST_RW_ACCEPT: assert property (
    map_wr && (in_rw16 || in_rw32) |=> map_wr_ok && map_rw_bank)
    else $error("write refused in writable range");
  AST_NO_BCAST: assert property (
    frame_end && rx_addr_n == ADDR_BCAST |=> st == ST_IDLE)
    else $error("broadcast request answered");
  AST_DEADLINE: assert property (
    sending |-> timer < TW'(RESP_CYCLES))
    else $error("reply deadline overrun");

endmodule : msid_id_report

// ===== rtl/msid_pkg.sv
// msid_pkg: constants, types and checksum helper for the
// identification-report responder.
// assumes: one 125 MHz clock domain shared by every user of the package.
package msid_pkg;

  // frame contents
  localparam logic [7:0]  FN_REPORT_ID = 8'h11;
  localparam logic [7:0]  BYTE_COUNT   = 8'h08;
  localparam logic [7:0]  DEV_STATE    = 8'hFF;
  localparam logic [7:0]  OC_TWO       = 8'h01;
  localparam logic [7:0]  VAR_4V       = 8'h00;
  localparam logic [7:0]  VAR_4I       = 8'h01;
  localparam logic [7:0]  VAR_2V2I     = 8'h02;
  localparam logic [7:0]  VAR_4T       = 8'h03;
  localparam logic [7:0]  MODE_RTU_8N2 = 8'h02;
  localparam logic [7:0]  ADDR_BCAST   = 8'h00;
  localparam logic [7:0]  ADDR_MIN     = 8'h01;
  localparam logic [7:0]  ADDR_MAX     = 8'hF7;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  // frame lengths and counters
  localparam logic [3:0]  REQ_HDR_LEN   = 4'h2;
  localparam logic [3:0]  CKS_LEN_RTU   = 4'h2;
  localparam logic [3:0]  CKS_LEN_ASCII = 4'h1;
  localparam int          PAY_LEN       = 11;
  localparam logic [3:0]  PAY_LAST      = 4'hA;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam logic [3:0]  CNT_ONE       = 4'h1;
  localparam logic [3:0]  CNT_SAT       = 4'hF;

  // checksum
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // holding-register map
  localparam logic [15:0] MAP_RO16_LO = 16'h1B58;
  localparam logic [15:0] MAP_RW16_LO = 16'h1C20;
  localparam logic [15:0] MAP_RW16_HI = 16'h1CE8;
  localparam logic [15:0] MAP_RO32_LO = 16'h1D4C;
  localparam logic [15:0] MAP_RW32_LO = 16'h1DB0;
  localparam logic [15:0] MAP_RW32_HI = 16'h1E14;
  localparam int          IDX_W       = 7;

  // timing
  localparam int CLK_HZ   = 125_000_000;
  localparam int RESP_MS  = 300;
  localparam int RESP_CYC = RESP_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_CKS  = 2'b10
  } msid_state_t;

  function automatic logic [15:0] msid_crc_step(input logic [15:0] c,
                                                input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {BYTE_ZERO, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : msid_crc_step

endpackage : msid_pkg
